// [rtl/pcmc_consts.vh]
// Overview of operation
// - Remote loop-back bit 9 turns on 100 Mb/s remote loop-back, reset off.
// - DC restoration bit 8 resets to one; clearing it disables DC restoration.
// - NRZI conversion bit 7, reset one, enables both conversions; clear bypasses.
// - Block code bit 6, reset one, enables 4B/5B coder; clear bypasses both.
// - Transmit isolate bit 5 isolates device from MII and transmit outputs.
// - Strapped address of zero sets transmit isolate at power-up or reset.
// - Read-only mode field bits 4..2 reports negotiating, speed/duplex or isolated.
// - Ternary code bypass bit 1 bypasses MLT3 encoder and decoder; reset zero.
// - Scrambler disable bit 0 stops scrambler and de-scrambler; reset zero.
// - Long reach bit 11 lowers 10 Mb/s squelch threshold; reset zero.
// - Address strap pins captured into bits 7..3 at reset; field stays writable.
// - PHY address travels most significant bit first in management frames.
// - Strapped address of zero sets isolate bit 10 of basic control.
// - After reset only writes to basic control bit 10 change isolate mode.
// - Writing zero address later does not enter isolate mode.
// - Preamble accept bit 1, reset one, admits frames with a preamble of one or more ones.
// - Preamble accept value shows in basic status bit 6.
// - Remote loop-back feeds recovered receive data back into MLT3 transmit input.
`ifndef PCMC_CONSTS_VH
`define PCMC_CONSTS_VH
`define PCMC_REG_BCTL        5'h00
`define PCMC_REG_BSTAT       5'h01
`define PCMC_REG_FCPC        5'h13
`define PCMC_REG_TMC         5'h14
`define PCMC_BCTL_ISOLATE    10
`define PCMC_BSTAT_PRE_ABIL  6
`define PCMC_BSTAT_AN_DONE   5
`define PCMC_FCPC_AN_DONE    12
`define PCMC_FCPC_RLB        9
`define PCMC_FCPC_DCR        8
`define PCMC_FCPC_NRZI       7
`define PCMC_FCPC_4B5B       6
`define PCMC_FCPC_TRANSMIT_ISOLATE      5
`define PCMC_FCPC_MODE_HI    4
`define PCMC_FCPC_MODE_LO    2
`define PCMC_FCPC_MLT        1
`define PCMC_FCPC_SCR        0
`define PCMC_TMC_LD          11
`define PCMC_TMC_PAD_HI      7
`define PCMC_TMC_PAD_LO      3
`define PCMC_TMC_PRE         1
`define PCMC_RST_RLB         1'b0
`define PCMC_RST_DCR         1'b1
`define PCMC_RST_NRZI        1'b1
`define PCMC_RST_4B5B        1'b1
`define PCMC_RST_TRANSMIT_ISOLATE       1'b0
`define PCMC_RST_MLT         1'b0
`define PCMC_RST_SCR         1'b0
`define PCMC_RST_LD          1'b0
`define PCMC_RST_PAD         5'h01
`define PCMC_RST_PRE         1'b1
`define PCMC_RST_ISOLATE     1'b0
`define PCMC_MODE_NEG        3'h0
`define PCMC_MODE_ISO        3'h7
`define PCMC_OP_READ         2'h2
`define PCMC_OP_WRITE        2'h1
`define PCMC_PREAMBLE_ONES   6'h20
`define PCMC_STRAP_WAIT      2'h3
`define PCMC_SKIP_BITS       5'h11
`endif

// [rtl/pcmc_regs.v]
`timescale 1ns/1ps
`include "pcmc_consts.vh"
module pcmc_regs (
  input  wire        core_clk,
  input  wire        nrst,
  input  wire        mdc,
  input  wire        mdio_in,
  output reg         mdio_out,
  output reg         mdio_oe_n,
  input  wire [4:0]  phy_address_strap,
  input  wire        an_busy,
  input  wire        an_complete,
  input  wire        negotiation_disabled,
  input  wire        link_speed_100,
  input  wire        link_full_duplex,
  output reg         remote_loop_enable,
  output reg         dc_restore_enable,
  output reg         nrzi_conversion_enable,
  output reg         block_code_enable,
  output reg         transmit_isolate,
  output reg         ternary_code_bypass,
  output reg         scrambler_disable,
  output reg         long_reach_squelch,
  output reg         preamble_suppress_accept,
  output reg         isolate,
  output reg  [4:0]  phy_address,
  output wire [2:0]  current_operating_mode
);
  localparam S_IDLE = 3'd0;
  localparam S_ST   = 3'd1;
  localparam S_HDR  = 3'd2;
  localparam S_TA   = 3'd3;
  localparam S_RDAT = 3'd4;
  localparam S_WDAT = 3'd5;
  localparam S_SKIP = 3'd6;

  reg  [2:0]  mdc_s;
  reg  [2:0]  mdio_s;
  reg  [4:0]  strap_s1;
  reg  [4:0]  strap_s2;
  reg  [4:0]  strap_s3;
  reg         mdc_q;
  reg         mdio_q;
  reg  [1:0]  strap_cnt;
  reg         strap_done;
  reg  [2:0]  state;
  reg  [4:0]  cnt;
  reg  [5:0]  ones;
  reg  [15:0] sh;
  reg  [15:0] rd_sh;
  reg         is_wr;
  reg  [4:0]  reg_a;
  reg  [15:0] rd_data;
  reg  [2:0]  mode;

  wire        mdc_agree = (mdc_s[1] == mdc_s[2]);
  wire        edge_rise = mdc_agree & mdc_s[2] & ~mdc_q;
  wire        bit_in    = (mdio_s[1] == mdio_s[2]) ? mdio_s[2] : mdio_q;
  wire [11:0] hdr       = {sh[10:0], bit_in};
  wire [15:0] wdata     = {sh[14:0], bit_in};
  wire        pre_ok    = (ones == `PCMC_PREAMBLE_ONES) ||
                          (preamble_suppress_accept && (ones != 6'h00));

  assign current_operating_mode = mode;

  // Mode report from datapath status
  always @* begin
    if (isolate && negotiation_disabled)
      mode = `PCMC_MODE_ISO;
    else if (an_busy)
      mode = `PCMC_MODE_NEG;
    else
      mode = {link_full_duplex, link_speed_100, ~link_speed_100};
  end

  // Read data; reserved positions stay zero
  always @* begin
    rd_data = 16'h0000;
    case (reg_a)
      `PCMC_REG_BCTL: begin
        rd_data[`PCMC_BCTL_ISOLATE] = isolate;
      end
      `PCMC_REG_BSTAT: begin
        rd_data[`PCMC_BSTAT_PRE_ABIL] = preamble_suppress_accept;
        rd_data[`PCMC_BSTAT_AN_DONE]  = an_complete;
      end
      `PCMC_REG_FCPC: begin
        rd_data[`PCMC_FCPC_AN_DONE] = an_complete;
        rd_data[`PCMC_FCPC_RLB]     = remote_loop_enable;
        rd_data[`PCMC_FCPC_DCR]     = dc_restore_enable;
        rd_data[`PCMC_FCPC_NRZI]    = nrzi_conversion_enable;
        rd_data[`PCMC_FCPC_4B5B]    = block_code_enable;
        rd_data[`PCMC_FCPC_TRANSMIT_ISOLATE]   = transmit_isolate;
        rd_data[`PCMC_FCPC_MODE_HI:`PCMC_FCPC_MODE_LO] = mode;
        rd_data[`PCMC_FCPC_MLT]     = ternary_code_bypass;
        rd_data[`PCMC_FCPC_SCR]     = scrambler_disable;
      end
      `PCMC_REG_TMC: begin
        rd_data[`PCMC_TMC_LD] = long_reach_squelch;
        rd_data[`PCMC_TMC_PAD_HI:`PCMC_TMC_PAD_LO] = phy_address;
        rd_data[`PCMC_TMC_PRE] = preamble_suppress_accept;
      end
      default: begin
        rd_data = 16'h0000;
      end
    endcase
  end

  // Pin synchronisers; a change counts when stages two and three agree
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mdc_s    <= 3'h0;
      mdio_s   <= 3'h7;
      strap_s1 <= 5'h00;
      strap_s2 <= 5'h00;
      strap_s3 <= 5'h00;
      mdc_q    <= 1'b0;
      mdio_q   <= 1'b1;
    end else begin
      mdc_s    <= {mdc_s[1:0], mdc};
      mdio_s   <= {mdio_s[1:0], mdio_in};
      strap_s1 <= phy_address_strap;
      strap_s2 <= strap_s1;
      strap_s3 <= strap_s2;
      if (mdc_agree)
        mdc_q <= mdc_s[2];
      mdio_q <= bit_in;
    end
  end

  // Register file, strap capture and management frame engine
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      remote_loop_enable       <= `PCMC_RST_RLB;
      dc_restore_enable        <= `PCMC_RST_DCR;
      nrzi_conversion_enable   <= `PCMC_RST_NRZI;
      block_code_enable        <= `PCMC_RST_4B5B;
      transmit_isolate         <= `PCMC_RST_TRANSMIT_ISOLATE;
      ternary_code_bypass      <= `PCMC_RST_MLT;
      scrambler_disable        <= `PCMC_RST_SCR;
      long_reach_squelch       <= `PCMC_RST_LD;
      phy_address              <= `PCMC_RST_PAD;
      preamble_suppress_accept <= `PCMC_RST_PRE;
      isolate                  <= `PCMC_RST_ISOLATE;
      strap_cnt  <= 2'h0;
      strap_done <= 1'b0;
      state      <= S_IDLE;
      cnt        <= 5'h00;
      ones       <= 6'h00;
      sh         <= 16'h0000;
      rd_sh      <= 16'h0000;
      is_wr      <= 1'b0;
      reg_a      <= 5'h00;
      mdio_out   <= 1'b1;
      mdio_oe_n  <= 1'b1;
    end else begin
      if (!strap_done) begin
        // Straps count only once stages two and three agree
        if (strap_cnt == `PCMC_STRAP_WAIT && strap_s2 == strap_s3) begin
          strap_done  <= 1'b1;
          phy_address <= strap_s3[4:0];
          if (strap_s3 == 5'h00) begin
            transmit_isolate <= 1'b1;
            isolate          <= 1'b1;
          end
        end else if (strap_cnt != `PCMC_STRAP_WAIT) begin
          strap_cnt <= strap_cnt + 2'h1;
        end
      end else if (edge_rise) begin
        case (state)
          S_IDLE: begin
            if (bit_in) begin
              if (ones != `PCMC_PREAMBLE_ONES)
                ones <= ones + 6'h01;
            end else begin
              ones <= 6'h00;
              if (pre_ok)
                state <= S_ST;
            end
          end
          S_ST: begin
            state <= bit_in ? S_HDR : S_IDLE;
            cnt   <= 5'h00;
          end
          S_HDR: begin
            sh  <= wdata;
            cnt <= cnt + 5'h01;
            if (cnt == 5'd11) begin
              cnt   <= 5'h00;
              reg_a <= hdr[4:0];
              is_wr <= (hdr[11:10] == `PCMC_OP_WRITE);
              if (hdr[9:5] == phy_address &&
                  (hdr[11:10] == `PCMC_OP_READ || hdr[11:10] == `PCMC_OP_WRITE))
                state <= S_TA;
              else
                state <= S_SKIP;
            end
          end
          S_TA: begin
            cnt <= cnt + 5'h01;
            if (!is_wr && cnt == 5'h00) begin
              mdio_out  <= 1'b0;
              mdio_oe_n <= 1'b0;
            end
            if (cnt == 5'h01) begin
              cnt <= 5'h00;
              if (is_wr) begin
                state <= S_WDAT;
              end else begin
                state    <= S_RDAT;
                mdio_out <= rd_data[15];
                rd_sh    <= {rd_data[14:0], 1'b0};
              end
            end
          end
          S_RDAT: begin
            cnt <= cnt + 5'h01;
            if (cnt == 5'd15) begin
              state     <= S_IDLE;
              mdio_out  <= 1'b1;
              mdio_oe_n <= 1'b1;
            end else begin
              mdio_out <= rd_sh[15];
              rd_sh    <= {rd_sh[14:0], 1'b0};
            end
          end
          S_WDAT: begin
            sh  <= wdata;
            cnt <= cnt + 5'h01;
            if (cnt == 5'd15) begin
              state <= S_IDLE;
              case (reg_a)
                `PCMC_REG_BCTL: begin
                  isolate <= wdata[`PCMC_BCTL_ISOLATE];
                end
                `PCMC_REG_FCPC: begin
                  remote_loop_enable     <= wdata[`PCMC_FCPC_RLB];
                  dc_restore_enable      <= wdata[`PCMC_FCPC_DCR];
                  nrzi_conversion_enable <= wdata[`PCMC_FCPC_NRZI];
                  block_code_enable      <= wdata[`PCMC_FCPC_4B5B];
                  transmit_isolate       <= wdata[`PCMC_FCPC_TRANSMIT_ISOLATE];
                  ternary_code_bypass    <= wdata[`PCMC_FCPC_MLT];
                  scrambler_disable      <= wdata[`PCMC_FCPC_SCR];
                end
                `PCMC_REG_TMC: begin
                  long_reach_squelch       <= wdata[`PCMC_TMC_LD];
                  phy_address              <= wdata[`PCMC_TMC_PAD_HI:`PCMC_TMC_PAD_LO];
                  preamble_suppress_accept <= wdata[`PCMC_TMC_PRE];
                end
                default: begin
                  is_wr <= 1'b0;
                end
              endcase
            end
          end
          S_SKIP: begin
            cnt <= cnt + 5'h01;
            if (cnt == `PCMC_SKIP_BITS)
              state <= S_IDLE;
          end
          default: begin
            state <= S_IDLE;
          end
        endcase
      end
    end
  end
endmodule // pcmc_regs

// [testbench/pcmc_properties.sv]
`timescale 1ns/1ps
module pcmc_properties (
  input wire       core_clk,
  input wire       nrst,
  input wire       mdc,
  input wire       mdio_out,
  input wire       mdio_oe_n,
  input wire [4:0] phy_address_strap,
  input wire       an_busy,
  input wire       negotiation_disabled,
  input wire       link_speed_100,
  input wire       link_full_duplex,
  input wire       transmit_isolate,
  input wire       isolate,
  input wire [4:0] phy_address,
  input wire [2:0] current_operating_mode
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  wire own = isolate && negotiation_disabled;
  sequence quiet; !mdc [*8]; endsequence
  sequence released; $rose(nrst); endsequence
  mode_iso_a: assert property (own |-> current_operating_mode == 3'h7)
    else $error("mode not isolated");
  mode_neg_a: assert property (!own && an_busy |-> current_operating_mode == 3'h0)
    else $error("mode not negotiating");
  mode_link_a: assert property (!own && !an_busy |-> current_operating_mode ==
    {link_full_duplex, link_speed_100, !link_speed_100}) else $error("mode wrong");
  turn_hold_a: assert property ($fell(mdio_oe_n) |-> !mdio_out ##1 !mdio_oe_n [*8])
    else $error("turnaround short");
  idle_release_a: assert property (quiet |-> mdio_oe_n)
    else $error("data driven while idle");
  quiet_hold_a: assert property (quiet |-> $stable({isolate, transmit_isolate,
    phy_address})) else $error("state moved without frame");
  strap_take_a: assert property (released |-> ##[2:6] phy_address == phy_address_strap)
    else $error("strap not captured");
  zero_strap_a: assert property (released ##0 phy_address_strap == 5'h00
    |-> ##[2:6] (transmit_isolate && isolate)) else $error("zero strap not isolated");
endmodule // pcmc_properties
bind pcmc_regs pcmc_properties chk (.core_clk, .nrst, .mdc, .mdio_out, .mdio_oe_n,
  .phy_address_strap, .an_busy, .negotiation_disabled, .link_speed_100,
  .link_full_duplex, .transmit_isolate, .isolate, .phy_address, .current_operating_mode);

// [testbench/pcmc_sme.sv]
`timescale 1ns/1ps
`include "pcmc_consts.vh"
module pcmc_sme (
  input  wire core_clk,
  input  wire line,
  output reg  mdc,
  output reg  drv,
  output reg  en
);
  reg s;
  initial begin
    mdc = 0;
    drv = 1;
    en = 0;
  end
  // Five core cycles per phase, read data sampled on the rising edge
  task clk_bit(input b);
    begin
      drv = b;
      repeat (5) @(negedge core_clk);
      mdc = 1;
      s = line;
      repeat (5) @(negedge core_clk);
      mdc = 0;
    end
  endtask
  task frame(input [1:0] op, input [4:0] ph, input [4:0] rg, input [15:0] wd,
             input [5:0] np, output [15:0] rd);
    integer i;
    reg [13:0] hdr;
    begin
      hdr = {2'b01, op, ph, rg};
      en = 1;
      for (i = 0; i < np; i = i + 1)
        clk_bit(1'b1);
      for (i = 13; i >= 0; i = i - 1)
        clk_bit(hdr[i]);
      if (op == `PCMC_OP_READ)
        en = 0;
      clk_bit(1'b1);
      clk_bit(1'b0);
      for (i = 15; i >= 0; i = i - 1) begin
        clk_bit(wd[i]);
        rd[i] = s;
      end
      en = 0;
    end
  endtask
endmodule // pcmc_sme

// [testbench/tb_top.sv]
`timescale 1ns/1ps
`include "pcmc_consts.vh"
module tb_top;
  reg         core_clk, nrst, iso_e;
  reg  [4:0]  phy_address_strap;
  reg         an_busy, an_complete, negotiation_disabled, link_speed_100, link_full_duplex;
  reg  [15:0] rd, wd, ctl, tmc, e_pin, e_fc;
  integer     n_mismatch, n_tests, seed, k, t;
  wire        mdc, drv, en, mdio_out, mdio_oe_n, isolate;
  wire        remote_loop_enable, dc_restore_enable, nrzi_conversion_enable;
  wire        block_code_enable, transmit_isolate, ternary_code_bypass, scrambler_disable;
  wire        long_reach_squelch, preamble_suppress_accept;
  wire [4:0]  phy_address;
  wire [2:0]  current_operating_mode;
  // Pulled up when nobody drives
  wire        mdio_in = !mdio_oe_n ? mdio_out : (en ? drv : 1'b1);
  wire [15:0] pins = {1'b0, remote_loop_enable, dc_restore_enable, nrzi_conversion_enable,
    block_code_enable, transmit_isolate, ternary_code_bypass, scrambler_disable,
    long_reach_squelch, preamble_suppress_accept, isolate, phy_address};
  pcmc_regs uut (.core_clk, .nrst, .mdc, .mdio_in, .mdio_out, .mdio_oe_n,
    .phy_address_strap, .an_busy, .an_complete, .negotiation_disabled, .link_speed_100,
    .link_full_duplex, .remote_loop_enable, .dc_restore_enable, .nrzi_conversion_enable,
    .block_code_enable, .transmit_isolate, .ternary_code_bypass, .scrambler_disable,
    .long_reach_squelch, .preamble_suppress_accept, .isolate, .phy_address,
    .current_operating_mode);
  pcmc_sme sme (.core_clk, .line(mdio_in), .mdc, .drv, .en);
  initial begin
    core_clk = 0;
    forever #50 core_clk = ~core_clk;
  end
  initial begin
    #10_000_000;
    n_mismatch = n_mismatch + 1;
    print_verdict;
  end
  function automatic [2:0] exp_mode();
    exp_mode = (iso_e & negotiation_disabled) ? 3'h7 : an_busy ? 3'h0 :
      {link_full_duplex, link_speed_100, ~link_speed_100};
  endfunction
  task note(input ok);
    begin
      n_tests = n_tests + 1;
      if (!ok) begin
        n_mismatch = n_mismatch + 1;
        $display("Error %0t: value differs", $time);
      end
    end
  endtask
  task chk_reg(input [15:0] g, input [15:0] e);
    note(g === e);
  endtask
  task chk_pin(input [15:0] g, input [15:0] e);
    note(g === e);
  endtask
  task wr(input [4:0] r, input [15:0] d, input [5:0] np);
    sme.frame(`PCMC_OP_WRITE, tmc[7:3], r, d, np, rd);
  endtask
  task rdr(input [4:0] r, input [15:0] m, input [15:0] e);
    begin
      sme.frame(`PCMC_OP_READ, tmc[7:3], r, 16'h0000, 6'h20, rd);
      chk_reg(rd & m, e);
    end
  endtask
  task env;
    begin
      @(negedge core_clk);
      k = $random(seed);
      {an_busy, an_complete, negotiation_disabled, link_speed_100, link_full_duplex} = k[4:0];
    end
  endtask
  task do_reset(input [4:0] s);
    begin
      @(negedge core_clk);
      nrst = 0;
      phy_address_strap = s;
      repeat (3) @(negedge core_clk);
      nrst = 1;
      repeat (12) @(negedge core_clk);
      tmc = {8'h00, s, 3'h2};
      iso_e = (s == 5'h00);
      ctl = iso_e ? 16'h01e0 : 16'h01c0;
    end
  endtask
  task check_all;
    begin
      e_pin = {1'b0, ctl[9:5], ctl[1:0], tmc[11], tmc[1], iso_e, tmc[7:3]};
      e_fc  = {3'h0, an_complete, 2'h0, ctl[9:5], exp_mode(), ctl[1:0]};
      chk_pin(pins, e_pin);
      chk_pin({13'h0000, current_operating_mode}, {13'h0000, exp_mode()});
      rdr(`PCMC_REG_FCPC, 16'hffff, e_fc);
      rdr(`PCMC_REG_TMC, 16'hffff, tmc & 16'h08fa);
      rdr(`PCMC_REG_BSTAT, 16'h0040, {9'h000, tmc[1], 6'h00});
      rdr(`PCMC_REG_BCTL, 16'h0400, {5'h00, iso_e, 10'h000});
      $display("Check at %0t done", $time);
    end
  endtask
  task print_verdict;
    begin
      $display("Tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  initial begin
    seed = 32'h8f15_89d8;
    n_mismatch = 0;
    n_tests = 0;
    nrst = 0;
    phy_address_strap = 5'h00;
    {an_busy, an_complete, negotiation_disabled, link_speed_100, link_full_duplex} = 5'h00;
    k = $random(seed);
    do_reset(k[4:0] | 5'h01);
    check_all;
    for (t = 0; t < 6; t = t + 1) begin
      k = $random(seed);
      ctl = (t == 0) ? 16'hffff : (t == 1) ? 16'h0000 : k[15:0];
      env;
      wr(`PCMC_REG_FCPC, ctl, 6'h20);
      check_all;
    end
    ctl = 16'h01c0;
    wr(`PCMC_REG_FCPC, ctl, 6'h20);
    for (t = 0; t < 4; t = t + 1) begin
      k = $random(seed);
      wd = (t == 0) ? 16'hffff : (t == 1) ? 16'h0000 : k[15:0];
      env;
      wr(`PCMC_REG_TMC, wd, 6'h20);
      tmc = wd;
      check_all;
    end
    wd = tmc | 16'h0002;
    wr(`PCMC_REG_TMC, wd, 6'h20);
    tmc = wd;
    ctl = 16'h0000;
    wr(`PCMC_REG_FCPC, ctl, 6'h01);
    check_all;
    wd = tmc & 16'hfffd;
    wr(`PCMC_REG_TMC, wd, 6'h20);
    tmc = wd;
    wr(`PCMC_REG_FCPC, 16'h03e3, 6'h01);
    sme.frame(`PCMC_OP_WRITE, tmc[7:3] ^ 5'h10, `PCMC_REG_FCPC, 16'h03e3, 6'h20, rd);
    check_all;
    wr(`PCMC_REG_BCTL, 16'h0400, 6'h20);
    iso_e = 1;
    check_all;
    do_reset(5'h00);
    check_all;
    print_verdict;
  end
endmodule // tb_top
